// >>> hw/cfmb_map.vh
// Constants for the CAN filter mask and buffer control block.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef CFMB_MAP_VH
`define CFMB_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CFMB_OFF_MSKSEL   8'h00
`define CFMB_OFF_MSID0    8'h04
`define CFMB_OFF_MSID1    8'h08
`define CFMB_OFF_MSID2    8'h0C
`define CFMB_OFF_MEID0    8'h10
`define CFMB_OFF_MEID1    8'h14
`define CFMB_OFF_MEID2    8'h18
`define CFMB_OFF_FULL_LO  8'h1C
`define CFMB_OFF_FULL_HI  8'h20
`define CFMB_OFF_OVF_LO   8'h24
`define CFMB_OFF_OVF_HI   8'h28
`define CFMB_OFF_CTL01    8'h2C
`define CFMB_OFF_CTL23    8'h30
`define CFMB_OFF_CTL45    8'h34
`define CFMB_OFF_CTL67    8'h38

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFMB_RST_16       16'h0000
`define CFMB_RST_32       32'h00000000

// ----------------------------------------------------------------
// Field layouts
// ----------------------------------------------------------------
`define CFMB_SEL_MASK0    2'b00
`define CFMB_SEL_MASK1    2'b01
`define CFMB_SEL_MASK2    2'b10
`define CFMB_SEL_NOMASK   2'b11
`define CFMB_MSID_IMPL    16'hFFEB
`define CFMB_MSID_TYPE_MATCH 3
`define CFMB_FSID_EXT     3
`define CFMB_CTL_DIR      7
`define CFMB_CTL_ABT      6
`define CFMB_CTL_LARB     5
`define CFMB_CTL_ERR      4
`define CFMB_CTL_REQ      3
`define CFMB_CTL_REPLY_EN 2
`define CFMB_CTL_PRI_LSB  0
`define CFMB_BSID_SID_LSB 2
`define CFMB_BSID_SRR     1
`define CFMB_BSID_IDE     0

`endif

// >>> hw/cfmb_filter_match.v
// One acceptance filter compare with its selectable mask.
// Assumes mask and filter words use the documented register layouts.
`timescale 1ns/1ps
`default_nettype none
`include "cfmb_map.vh"

module cfmb_filter_match (
    input wire [1:0] mask_sel_i,
    input wire [47:0] msk_sid_i,
    input wire [47:0] msk_eid_i,
    input wire [15:0] flt_sid_i,
    input wire [15:0] flt_eid_i,
    input wire [28:0] rx_id_i,
    input wire rx_ext_i,
    output wire match_o
);

// ----------------------------------------------------------------
// Mask source
// ----------------------------------------------------------------
reg [15:0] ms;
reg [15:0] me;

always @* begin
    case (mask_sel_i)
        `CFMB_SEL_MASK0: begin
            ms = msk_sid_i[15:0];
            me = msk_eid_i[15:0];
        end
        `CFMB_SEL_MASK1: begin
            ms = msk_sid_i[31:16];
            me = msk_eid_i[31:16];
        end
        `CFMB_SEL_MASK2: begin
            ms = msk_sid_i[47:32];
            me = msk_eid_i[47:32];
        end
        default: begin
            // Without a mask every bit and the type are compared
            ms = `CFMB_MSID_IMPL;
            me = 16'hFFFF;
        end
    endcase
end

// ----------------------------------------------------------------
// Compare
// ----------------------------------------------------------------
wire [28:0] inc = {ms[15:5], ms[1:0], me};
wire [28:0] fid = {flt_sid_i[15:5], flt_sid_i[1:0], flt_eid_i};
wire [28:0] diff = (fid ^ rx_id_i) & inc;
wire sid_ok = ~|diff[28:18];
wire all_ok = ~|diff;
wire type_match = ms[`CFMB_MSID_TYPE_MATCH];
wire fext = flt_sid_i[`CFMB_FSID_EXT];
wire type_ok = ~type_match | (fext == rx_ext_i);
wire id_ok = rx_ext_i ? all_ok : sid_ok;

assign match_o = type_ok & id_ok;

endmodule // cfmb_filter_match
`default_nettype wire

// >>> hw/cfmb_core.v
// CAN filter mask select, receive full/overflow flags, buffer pair
// control and transmit selection behind an AHB-Lite slave.
// Assumes frame, store and transmit events come from same-clock logic.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cfmb_map.vh"

module cfmb_core (
    input wire clk_sys_i,
    input wire sys_rst_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [31:0] hrdata_o,
    input wire [127:0] flt_sid_i,
    input wire [127:0] flt_eid_i,
    input wire rx_frame_valid_i,
    input wire [28:0] rx_id_i,
    input wire rx_ext_i,
    output reg [7:0] filter_hit_o,
    output reg filter_hit_valid_o,
    input wire rx_store_i,
    input wire [4:0] rx_store_buf_i,
    input wire rx_store_rtr_i,
    input wire [2:0] tx_buf_i,
    input wire tx_ok_i,
    input wire tx_aborted_i,
    input wire tx_arb_lost_i,
    input wire tx_err_i,
    output reg tx_pending_o,
    output reg [2:0] tx_sel_o,
    output reg [7:0] abort_req_o,
    input wire [15:0] msgbuf_sid_word_i,
    output reg [10:0] tx_sid_o,
    output reg tx_srr_o,
    output reg tx_ide_o
);

// ----------------------------------------------------------------
// Register state
// ----------------------------------------------------------------
reg [15:0] msksel_reg;
reg [15:0] msk_sid_reg [0:2];
reg [15:0] msk_eid_reg [0:2];
reg [31:0] full_reg, full_next;
reg [31:0] ovf_reg, ovf_next;
reg [7:0] dir_reg, dir_next;
reg [7:0] abt_reg, abt_next;
reg [7:0] larb_reg, larb_next;
reg [7:0] err_reg, err_next;
reg [7:0] req_reg, req_next;
reg [7:0] reply_en_reg, reply_en_next;
reg [15:0] pri_reg, pri_next;
reg [7:0] abp_reg, abp_next;
reg [7:0] addr_reg;
reg wr_pend_reg;
reg rd_pend_reg;

// ----------------------------------------------------------------
// AHB-Lite slave
// ----------------------------------------------------------------
// Reads take one wait state so a write just before is always visible
wire acc = hsel_i & htrans_i[1] & hready_i;
wire wsel = wr_pend_reg & hready_i;

always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        addr_reg <= 8'h00;
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        hreadyout_o <= 1'b1;
        hresp_o <= 1'b0;
    end else begin
        wr_pend_reg <= acc & hwrite_i;
        rd_pend_reg <= acc & ~hwrite_i;
        hreadyout_o <= ~(acc & ~hwrite_i);
        hresp_o <= 1'b0;
        if (acc) begin
            addr_reg <= haddr_i[7:0];
        end
    end
end

reg [15:0] rd_data;
reg [15:0] ctl_word;
integer k;

always @* begin
    ctl_word = 16'h0000;
    case (addr_reg)
        `CFMB_OFF_MSKSEL: rd_data = msksel_reg;
        `CFMB_OFF_MSID0: rd_data = msk_sid_reg[0];
        `CFMB_OFF_MSID1: rd_data = msk_sid_reg[1];
        `CFMB_OFF_MSID2: rd_data = msk_sid_reg[2];
        `CFMB_OFF_MEID0: rd_data = msk_eid_reg[0];
        `CFMB_OFF_MEID1: rd_data = msk_eid_reg[1];
        `CFMB_OFF_MEID2: rd_data = msk_eid_reg[2];
        `CFMB_OFF_FULL_LO: rd_data = full_reg[15:0];
        `CFMB_OFF_FULL_HI: rd_data = full_reg[31:16];
        `CFMB_OFF_OVF_LO: rd_data = ovf_reg[15:0];
        `CFMB_OFF_OVF_HI: rd_data = ovf_reg[31:16];
        default: rd_data = 16'h0000;
    endcase
    for (k = 0; k < 8; k = k + 1) begin
        if (addr_reg == `CFMB_OFF_CTL01 + (k / 2) * 4) begin
            ctl_word[(k % 2) * 8 +: 8] = {dir_reg[k], abt_reg[k],
                larb_reg[k], err_reg[k], req_reg[k], reply_en_reg[k],
                pri_reg[2 * k +: 2]};
            rd_data = ctl_word;
        end
    end
end

always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        hrdata_o <= `CFMB_RST_32;
    end else if (rd_pend_reg) begin
        hrdata_o <= {16'h0000, rd_data};
    end
end

// ----------------------------------------------------------------
// Mask registers
// ----------------------------------------------------------------
integer m;

always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        msksel_reg <= `CFMB_RST_16;
        for (m = 0; m < 3; m = m + 1) begin
            msk_sid_reg[m] <= `CFMB_RST_16;
            msk_eid_reg[m] <= `CFMB_RST_16;
        end
    end else if (wsel) begin
        if (addr_reg == `CFMB_OFF_MSKSEL) begin
            msksel_reg <= hwdata_i[15:0];
        end
        for (m = 0; m < 3; m = m + 1) begin
            if (addr_reg == `CFMB_OFF_MSID0 + m * 4) begin
                // Unimplemented bits 4 and 2 always read as zero
                msk_sid_reg[m] <= hwdata_i[15:0] & `CFMB_MSID_IMPL;
            end
            if (addr_reg == `CFMB_OFF_MEID0 + m * 4) begin
                msk_eid_reg[m] <= hwdata_i[15:0];
            end
        end
    end
end

// ----------------------------------------------------------------
// Acceptance filters
// ----------------------------------------------------------------
wire [47:0] msk_sid_all = {msk_sid_reg[2], msk_sid_reg[1], msk_sid_reg[0]};
wire [47:0] msk_eid_all = {msk_eid_reg[2], msk_eid_reg[1], msk_eid_reg[0]};
wire [7:0] hit;

genvar g;
generate
    for (g = 0; g < 8; g = g + 1) begin : gen_flt
        cfmb_filter_match u_match (
            .mask_sel_i(msksel_reg[2 * g +: 2]),
            .msk_sid_i(msk_sid_all),
            .msk_eid_i(msk_eid_all),
            .flt_sid_i(flt_sid_i[16 * g +: 16]),
            .flt_eid_i(flt_eid_i[16 * g +: 16]),
            .rx_id_i(rx_id_i),
            .rx_ext_i(rx_ext_i),
            .match_o(hit[g])
        );
    end
endgenerate

always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        filter_hit_o <= 8'h00;
        filter_hit_valid_o <= 1'b0;
    end else begin
        filter_hit_valid_o <= rx_frame_valid_i;
        if (rx_frame_valid_i) begin
            filter_hit_o <= hit;
        end
    end
end

// ----------------------------------------------------------------
// Receive flags and buffer control
// ----------------------------------------------------------------
wire [31:0] store_dec = 32'h00000001 << rx_store_buf_i;
wire [7:0] tx_dec = 8'h01 << tx_buf_i;
wire store_low = (rx_store_buf_i[4:3] == 2'b00);
// A remote frame steered to a transmit buffer is not stored; it triggers a reply only when its reply enable bit is set
wire to_txbuf = store_low & dir_reg[rx_store_buf_i[2:0]];
wire fill = rx_store_i & ~(to_txbuf & rx_store_rtr_i);
wire [31:0] set_full = fill ? (store_dec & ~full_reg) : 32'h00000000;
wire [31:0] set_ovf = fill ? (store_dec & full_reg) : 32'h00000000;
reg [31:0] clr_full, clr_ovf;
reg [7:0] wb;
reg wen;
reg sw_set, sw_clr, rr;
wire [15:0] clr_word = ~hwdata_i[15:0];
integer i;

always @* begin
    wb = 8'h00;
    wen = 1'b0;
    sw_set = 1'b0;
    sw_clr = 1'b0;
    rr = 1'b0;
    clr_full = 32'h00000000;
    clr_ovf = 32'h00000000;
    // Writing zero clears a flag; writing one leaves it
    if (wsel && addr_reg == `CFMB_OFF_FULL_LO) clr_full[15:0] = clr_word;
    if (wsel && addr_reg == `CFMB_OFF_FULL_HI) clr_full[31:16] = clr_word;
    if (wsel && addr_reg == `CFMB_OFF_OVF_LO) clr_ovf[15:0] = clr_word;
    if (wsel && addr_reg == `CFMB_OFF_OVF_HI) clr_ovf[31:16] = clr_word;
    full_next = (full_reg & ~clr_full) | set_full;
    ovf_next = (ovf_reg & ~clr_ovf) | set_ovf;
    dir_next = dir_reg;
    abt_next = abt_reg;
    larb_next = larb_reg;
    err_next = err_reg;
    req_next = req_reg;
    reply_en_next = reply_en_reg;
    pri_next = pri_reg;
    abp_next = abp_reg;
    for (i = 0; i < 8; i = i + 1) begin
        wen = wsel && (addr_reg == `CFMB_OFF_CTL01 + (i / 2) * 4);
        wb = hwdata_i[(i % 2) * 8 +: 8];
        sw_set = wen & wb[`CFMB_CTL_REQ] & ~req_reg[i];
        sw_clr = wen & ~wb[`CFMB_CTL_REQ] & req_reg[i];
        rr = rx_store_i & rx_store_rtr_i & store_low & store_dec[i]
            & dir_reg[i] & reply_en_reg[i];
        if (wen) begin
            dir_next[i] = wb[`CFMB_CTL_DIR];
            reply_en_next[i] = wb[`CFMB_CTL_REPLY_EN];
            pri_next[2 * i +: 2] = wb[`CFMB_CTL_PRI_LSB +: 2];
        end
        if (sw_clr) begin
            req_next[i] = 1'b0;
            abp_next[i] = 1'b1;
        end
        if (tx_ok_i & tx_dec[i]) begin
            req_next[i] = 1'b0;
            abt_next[i] = 1'b0;
            abp_next[i] = 1'b0;
        end
        if (sw_set | rr) begin
            req_next[i] = 1'b1;
            abp_next[i] = 1'b0;
            abt_next[i] = 1'b0;
            larb_next[i] = 1'b0;
            err_next[i] = 1'b0;
        end
        // Hardware events win over the clear of a new request
        if (tx_aborted_i & tx_dec[i]) begin
            abt_next[i] = 1'b1;
            abp_next[i] = 1'b0;
            if (~(sw_set | rr)) req_next[i] = 1'b0;
        end
        if (tx_arb_lost_i & tx_dec[i]) larb_next[i] = 1'b1;
        if (tx_err_i & tx_dec[i]) err_next[i] = 1'b1;
    end
end

always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        full_reg <= `CFMB_RST_32;
        ovf_reg <= `CFMB_RST_32;
        dir_reg <= 8'h00;
        abt_reg <= 8'h00;
        larb_reg <= 8'h00;
        err_reg <= 8'h00;
        req_reg <= 8'h00;
        reply_en_reg <= 8'h00;
        pri_reg <= `CFMB_RST_16;
        abp_reg <= 8'h00;
    end else begin
        full_reg <= full_next;
        ovf_reg <= ovf_next;
        dir_reg <= dir_next;
        abt_reg <= abt_next;
        larb_reg <= larb_next;
        err_reg <= err_next;
        req_reg <= req_next;
        reply_en_reg <= reply_en_next;
        pri_reg <= pri_next;
        abp_reg <= abp_next;
    end
end

// ----------------------------------------------------------------
// Transmit selection
// ----------------------------------------------------------------
// Ties go to the lowest buffer number
reg found;
reg [2:0] best;
reg [1:0] best_pri;
integer j;

always @* begin
    found = 1'b0;
    best = 3'b000;
    best_pri = 2'b00;
    for (j = 0; j < 8; j = j + 1) begin
        if (dir_reg[j] & req_reg[j] & ~abp_reg[j]) begin
            if (!found || pri_reg[2 * j +: 2] > best_pri) begin
                found = 1'b1;
                best = j[2:0];
                best_pri = pri_reg[2 * j +: 2];
            end
        end
    end
end

always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
        tx_pending_o <= 1'b0;
        tx_sel_o <= 3'b000;
        abort_req_o <= 8'h00;
        tx_sid_o <= 11'h000;
        tx_srr_o <= 1'b0;
        tx_ide_o <= 1'b0;
    end else begin
        tx_pending_o <= found;
        tx_sel_o <= best;
        abort_req_o <= abp_reg;
        // Buffer words come from DMA RAM; upper three bits ignored
        tx_sid_o <= msgbuf_sid_word_i[`CFMB_BSID_SID_LSB +: 11];
        tx_srr_o <= msgbuf_sid_word_i[`CFMB_BSID_SRR];
        tx_ide_o <= msgbuf_sid_word_i[`CFMB_BSID_IDE];
    end
end

endmodule // cfmb_core
`default_nettype wire

// >>> testbench/cfmb_core_monitor.sv
// Concurrent checks on the ports of the CAN filter and buffer block.
// Assumes it is bound to cfmb_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cfmb_core_monitor (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic rx_frame_valid_i,
    input wire logic filter_hit_valid_o,
    input wire logic [2:0] tx_buf_i,
    input wire logic tx_aborted_i,
    input wire logic [7:0] abort_req_o,
    input wire logic [15:0] msgbuf_sid_word_i,
    input wire logic [10:0] tx_sid_o,
    input wire logic tx_srr_o,
    input wire logic tx_ide_o
);
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // Helper nets so that $past sees whole signals
    wire logic [10:0] sid_field = msgbuf_sid_word_i[12:2];
    wire logic srr_field = msgbuf_sid_word_i[1];
    wire logic ide_field = msgbuf_sid_word_i[0];
    sequence s_rd_addr;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    endsequence
    sequence s_rd_data;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    property p_resp_okay;
        hresp_o == 1'b0;
    endproperty
    a_resp_okay: assert property (p_resp_okay) else $error("bad response");
    property p_read_wait;
        s_rd_addr |=> s_rd_data;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read timing");
    property p_write_nowait;
        hsel_i && htrans_i[1] && hready_i && hwrite_i |=> hreadyout_o;
    endproperty
    a_write_nowait: assert property (p_write_nowait) else $error("write wait");
    property p_hit_valid;
        rx_frame_valid_i |=> filter_hit_valid_o;
    endproperty
    a_hit_valid: assert property (p_hit_valid) else $error("no hit");
    property p_hit_pulse;
        !rx_frame_valid_i |=> !filter_hit_valid_o;
    endproperty
    a_hit_pulse: assert property (p_hit_pulse) else $error("stray hit");
    property p_sid_decode;
        1'b1 |=> tx_sid_o == $past(sid_field);
    endproperty
    a_sid_decode: assert property (p_sid_decode) else $error("sid");
    property p_srr_decode;
        1'b1 |=> tx_srr_o == $past(srr_field);
    endproperty
    a_srr_decode: assert property (p_srr_decode) else $error("srr");
    property p_ide_decode;
        1'b1 |=> tx_ide_o == $past(ide_field);
    endproperty
    a_ide_decode: assert property (p_ide_decode) else $error("ide");
    // The abort request output trails its internal flag by one cycle
    property p_abort_done;
        tx_aborted_i |=> ##1 abort_req_o[$past(tx_buf_i, 2)] == 1'b0;
    endproperty
    a_abort_done: assert property (p_abort_done) else $error("abort");
endmodule // cfmb_core_monitor
`default_nettype wire

// >>> testbench/cfmb_can_node.sv
// Behavioural model of the far CAN nodes and of the frame engine.
// Assumes every task is entered just after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module cfmb_can_node (
    input wire logic clk_i,
    output logic frame_valid_o,
    output logic [28:0] id_o,
    output logic ext_o,
    output logic store_o,
    output logic [4:0] store_buf_o,
    output logic rtr_o,
    output logic [2:0] tx_buf_o,
    output logic [3:0] tx_evt_o
);
    // ----------------------------------------------------------
    // Events
    // ----------------------------------------------------------
    initial begin
        frame_valid_o = 1'b0;
        id_o = 29'h0;
        ext_o = 1'b0;
        store_o = 1'b0;
        store_buf_o = 5'h0;
        rtr_o = 1'b0;
        tx_buf_o = 3'h0;
        tx_evt_o = 4'h0;
    end
    task automatic send_frame(input logic [28:0] id, input logic ext);
        id_o <= id;
        ext_o <= ext;
        frame_valid_o <= 1'b1;
        @(posedge clk_i);
        frame_valid_o <= 1'b0;
        // Released lines show no stale identifier
        id_o <= ~id;
    endtask
    task automatic store(input logic [4:0] b, input logic r);
        store_buf_o <= b;
        rtr_o <= r;
        store_o <= 1'b1;
        @(posedge clk_i);
        store_o <= 1'b0;
        store_buf_o <= ~b;
    endtask
    // Event bits: 0 sent, 1 aborted, 2 lost arbitration, 3 bus error
    task automatic tx_event(input logic [2:0] b, input logic [3:0] e);
        tx_buf_o <= b;
        tx_evt_o <= e;
        @(posedge clk_i);
        tx_evt_o <= 4'h0;
        tx_buf_o <= ~b;
    endtask
endmodule // cfmb_can_node
`default_nettype wire

// >>> testbench/cfmb_core_test.sv
// Self-checking bench for cfmb_core with an AHB-Lite master.
// Assumes the monitor and the CAN node model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module cfmb_core_test;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} cfmb_row_t;
    logic clk_sys_i, sys_rst_i, hsel_i, hwrite_i;
    logic [31:0] haddr_i, hwdata_i, v;
    logic [1:0] htrans_i;
    logic [127:0] flt_sid_i, flt_eid_i;
    logic [15:0] msgbuf_sid_word_i;
    wire logic hreadyout_o, hresp_o, hit_v, pend, srr, ide, fv, fext, st, rtr;
    wire logic [31:0] hrdata_o;
    wire logic [7:0] hit, abrt;
    wire logic [2:0] sel, tbuf;
    wire logic [10:0] sid;
    wire logic [28:0] fid;
    wire logic [4:0] sbuf;
    wire logic [3:0] tevt;
    integer mismatches, checked, i;
    cfmb_row_t rows [0:6] = '{'{8'h00, 32'h0000FFFF, 32'h0000FFFF},
        '{8'h04, 32'h0000FFFF, 32'h0000FFEB}, '{8'h14, 32'h0000A5A5,
        32'h0000A5A5}, '{8'h1C, 32'h0000FFFF, 32'h00000000}, '{8'h28,
        32'h0000FFFF, 32'h00000000}, '{8'h38, 32'h00007777, 32'h00000707},
        '{8'h3C, 32'h0000FFFF, 32'h00000000}};
    logic [28:0] f_id [0:3] = '{29'h048C0000, 29'h04900000, 29'h048C0002,
        29'h048C0001};
    logic f_ext [0:3] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] f_hit [0:3] = '{8'h0F, 8'h02, 8'h01, 8'h00};
    cfmb_core cfmb_core_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o), .flt_sid_i(flt_sid_i), .flt_eid_i(flt_eid_i),
        .rx_frame_valid_i(fv), .rx_id_i(fid), .rx_ext_i(fext),
        .filter_hit_o(hit), .filter_hit_valid_o(hit_v), .rx_store_i(st),
        .rx_store_buf_i(sbuf), .rx_store_rtr_i(rtr), .tx_buf_i(tbuf),
        .tx_ok_i(tevt[0]), .tx_aborted_i(tevt[1]), .tx_arb_lost_i(tevt[2]),
        .tx_err_i(tevt[3]), .tx_pending_o(pend), .tx_sel_o(sel),
        .abort_req_o(abrt), .msgbuf_sid_word_i(msgbuf_sid_word_i),
        .tx_sid_o(sid), .tx_srr_o(srr), .tx_ide_o(ide));
    cfmb_can_node cfmb_can_node_i (.clk_i(clk_sys_i), .frame_valid_o(fv),
        .id_o(fid), .ext_o(fext), .store_o(st), .store_buf_o(sbuf),
        .rtr_o(rtr), .tx_buf_o(tbuf), .tx_evt_o(tevt));
    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Bounded wait for a flag sampled at rising edges
    task wait_for(input logic sig_sel);
        integer n;
        n = 0;
        @(posedge clk_sys_i);
        while ((sig_sel ? hit_v : hreadyout_o) !== 1'b1) begin
            n = n + 1;
            if (n > 20) begin
                mismatches = mismatches + 1;
                $display("unexpected at %0t: hang", $time);
                wrap_up;
            end
            @(posedge clk_sys_i);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        haddr_i <= {24'h0, a};
        hwrite_i <= wr;
        htrans_i <= 2'b10;
        wait_for(1'b0);
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        wait_for(1'b0);
        v = hrdata_o;
    endtask
    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(v, exp);
    endtask
    task pause;
        repeat (3) @(posedge clk_sys_i);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        {hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
        {flt_sid_i, flt_eid_i, msgbuf_sid_word_i} = '0;
        mismatches = 0;
        checked = 0;
        sys_rst_i = 1'b1;
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        hsel_i <= 1'b1;
        for (i = 0; i < 7; i = i + 1) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("test rows done");
        sys_rst_i <= 1'b1;
        pause;
        sys_rst_i <= 1'b0;
        for (i = 0; i < 15; i = i + 1)
            rd_chk(8'(4 * i), 32'h0);
        $display("test reset done");
        bus(1'b1, 8'h00, 32'h000000E4);
        bus(1'b1, 8'h04, 32'h0000FFE0);
        bus(1'b1, 8'h08, 32'h00000008);
        bus(1'b1, 8'h0C, 32'h0000FFE8);
        bus(1'b1, 8'h10, 32'h00000001);
        flt_sid_i <= {64'h0, {4{16'h2460}}};
        for (i = 0; i < 4; i = i + 1) begin
            cfmb_can_node_i.send_frame(f_id[i], f_ext[i]);
            wait_for(1'b1);
            check(hit, f_hit[i]);
        end
        $display("test filters done");
        cfmb_can_node_i.store(5'd9, 1'b0);
        rd_chk(8'h1C, 32'h00000200);
        cfmb_can_node_i.store(5'd9, 1'b0);
        rd_chk(8'h24, 32'h00000200);
        cfmb_can_node_i.store(5'd20, 1'b0);
        rd_chk(8'h20, 32'h00000010);
        bus(1'b1, 8'h1C, 32'h0000FDFF);
        rd_chk(8'h1C, 32'h0);
        rd_chk(8'h24, 32'h00000200);
        bus(1'b1, 8'h24, 32'h0);
        rd_chk(8'h24, 32'h0);
        $display("test flags done");
        bus(1'b1, 8'h2C, 32'h00008B89);
        pause;
        check(pend, 1'b1);
        check(sel, 3'd1);
        cfmb_can_node_i.tx_event(3'd1, 4'b0100);
        rd_chk(8'h2C, 32'h0000AB89);
        cfmb_can_node_i.tx_event(3'd0, 4'b1000);
        rd_chk(8'h2C, 32'h0000AB99);
        bus(1'b1, 8'h2C, 32'h00008399);
        pause;
        check(abrt, 8'h02);
        check(sel, 3'd0);
        cfmb_can_node_i.tx_event(3'd1, 4'b0010);
        rd_chk(8'h2C, 32'h0000E399);
        check(abrt, 8'h00);
        bus(1'b1, 8'h2C, 32'h00008B99);
        rd_chk(8'h2C, 32'h00008B99);
        cfmb_can_node_i.tx_event(3'd1, 4'b0001);
        rd_chk(8'h2C, 32'h00008399);
        $display("test transmit done");
        bus(1'b1, 8'h30, 32'h00008084);
        cfmb_can_node_i.store(5'd2, 1'b1);
        rd_chk(8'h30, 32'h0000808C);
        cfmb_can_node_i.store(5'd3, 1'b1);
        rd_chk(8'h30, 32'h0000808C);
        rd_chk(8'h1C, 32'h0);
        msgbuf_sid_word_i <= 16'h1696;
        pause;
        check(sid, 11'h5A5);
        check(srr, 1'b1);
        msgbuf_sid_word_i <= 16'hE001;
        pause;
        check({sid, srr}, 12'h000);
        check(ide, 1'b1);
        $display("test remote and word done");
        wrap_up;
    end
endmodule // cfmb_core_test
bind cfmb_core cfmb_core_monitor cfmb_core_monitor_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .rx_frame_valid_i(rx_frame_valid_i),
    .filter_hit_valid_o(filter_hit_valid_o), .tx_buf_i(tx_buf_i),
    .tx_aborted_i(tx_aborted_i), .abort_req_o(abort_req_o),
    .msgbuf_sid_word_i(msgbuf_sid_word_i), .tx_sid_o(tx_sid_o),
    .tx_srr_o(tx_srr_o), .tx_ide_o(tx_ide_o));
`default_nettype wire
